// ### rtl/ddrpd_host.sv
/*
  host side power-down and self-refresh temperature control for a DDR3 part.
  assumes the memory clock mem_ck is made elsewhere and is sampled here.
*/
// Operation
// [RULE1] above 85 C refresh twice as often, 32 ms period
// [RULE2] self-refresh above 85 C only with auto rate or extended flag
// [RULE3] mode register 2 bit 7 picks normal or extended range
// [RULE4] bit 6 set lets the device pace its own self-refresh
// [RULE5] never set bit 7 while bit 6 is set
// [RULE6] both bits clear allow self-refresh only in normal range
// [RULE7] entry is clock enable low with a no-operation command
// [RULE8] no entry while register set, calibration, read or write runs
// [RULE9] entry allowed while activate, precharge or refresh runs
// [RULE10] wait one clock after activate, precharge or refresh
// [RULE11] read waits latency plus five; register set waits update delay
// [RULE12] write waits latency plus four or two plus recovery, plus one; the code adds the one only for write with auto precharge
// [RULE13] slow exit makes termination asynchronous around power-down; the code does so only with no bank open
// [RULE14] device gates buffers except clock, termination, enable, reset
// [RULE15] only no-operation commands until buffer disable delay passes
// [RULE16] prefer entry with the delay-locked loop locked
// [RULE17] entry while unlocked needs a loop reset after exit
// [RULE18] open bank gives active power-down, else precharge power-down
// [RULE19] hold enable low the minimum time, at most nine intervals
// [RULE20] exit high with no-operation, hold high, wait exit latencies
`timescale 1ns/1ps
module ddrpd_host (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               mem_ck,
  input  wire logic               cmd_valid,
  input  wire ddrpd_pkg::ddrpd_cmd_type cmd_in,
  input  wire logic [3:0]         rl,
  input  wire logic [3:0]         wl,
  input  wire logic [3:0]         wr,
  input  wire logic               bc4_fixed,
  input  wire logic               pd_req,
  input  wire logic               sr_req,
  input  wire logic               wake_req,
  input  wire logic               want_auto_rate,
  input  wire logic               want_ext_range,
  input  wire logic               slow_exit,
  input  wire logic               dll_locked,
  input  wire logic               bank_open,
  input  wire logic [7:0]         temp_c,
  output logic                    cmd_accept,
  output logic                    cke,
  output ddrpd_pkg::ddrpd_cmd_type cmd_out,
  output logic                    cmd_strobe,
  output logic                    auto_refresh_rate,
  output logic                    extended_range_flag,
  output logic                    odt_async,
  output logic                    dll_reset_req,
  output logic                    refresh_due,
  output logic                    in_power_down,
  output logic                    active_pd
);
  import ddrpd_pkg::*;

  typedef struct packed {
    logic              ck_s1;
    logic              ck_s2;
    logic              ck_s3;
    ddrpd_state_type   state;
    logic [`DDRPD_CNT_W-1:0] cnt;
    logic [`DDRPD_CNT_W-1:0] refi_cnt;
    logic [3:0]        refi_n;
    logic              cke;
    ddrpd_cmd_type     cmd;
    logic              strobe;
    logic              accept;
    logic              auto_rate;
    logic              ext_range;
    logic              odt_async;
    logic              unlocked_entry;
    logic              dll_reset;
    logic              ref_due;
    logic              active;
  } ddrpd_host_type;

  ddrpd_host_type st_ff;
  ddrpd_host_type nxt_st;
  ddrpd_gap_if    gi ();

  logic ck_rise;
  logic hot;
  logic sr_ok;
  logic [`DDRPD_CNT_W-1:0] refi_lim;

  ddrpd_gap u_gap (
    .clock (clock),
    .rst   (rst),
    .g     (gi.gap)
  );

  assign ck_rise  = st_ff.ck_s2 && !st_ff.ck_s3;
  assign hot      = temp_c > 8'(`DDRPD_HOT_C);
  assign refi_lim = hot ? `DDRPD_CNT_W'(`DDRPD_REFI_HOT_CYC) // RULE1
                        : `DDRPD_CNT_W'(`DDRPD_REFI_NORM_CYC);
  assign sr_ok    = !hot || st_ff.auto_rate || st_ff.ext_range; // RULE2 RULE6

  assign gi.issue     = st_ff.strobe && ck_rise;
  assign gi.tick      = ck_rise;
  assign gi.cmd       = st_ff.cmd;
  assign gi.rl        = rl;
  assign gi.wl        = wl;
  assign gi.wr        = wr;
  assign gi.bc4_fixed = bc4_fixed;

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.ck_s1  = mem_ck;
    nxt_st.ck_s2  = st_ff.ck_s1;
    nxt_st.ck_s3  = st_ff.ck_s2;
    nxt_st.accept = 1'b0;
    nxt_st.auto_rate = want_auto_rate; // RULE4
    nxt_st.ext_range = want_ext_range && !want_auto_rate; // RULE3 RULE5
    if (st_ff.strobe && ck_rise) begin
      nxt_st.strobe = 1'b0;
      nxt_st.cmd    = DDRPD_CMD_NOP;
    end
    if (st_ff.refi_cnt >= refi_lim - `DDRPD_CNT_W'(1)) begin // RULE1
      nxt_st.refi_cnt = '0;
      nxt_st.ref_due  = 1'b1;
      if (st_ff.refi_n != 4'hF) begin
        nxt_st.refi_n = st_ff.refi_n + 4'h1;
      end
    end else begin
      nxt_st.refi_cnt = st_ff.refi_cnt + `DDRPD_CNT_W'(1);
    end
    if (ck_rise) begin
      if (st_ff.cnt != '0) begin
        nxt_st.cnt = st_ff.cnt - `DDRPD_CNT_W'(1);
      end
    end
    if (cmd_valid && cmd_in == DDRPD_CMD_REF) begin
      nxt_st.ref_due = 1'b0;
    end
    unique case (st_ff.state)
      DDRPD_ST_RUN: begin
        // launch only mid high phase so the next memory rise sees it
        if (cmd_valid && !st_ff.strobe && st_ff.cnt == '0 &&
            st_ff.ck_s2 && st_ff.ck_s3 &&
            (cmd_in != DDRPD_CMD_SRE || sr_ok)) begin // RULE2
          nxt_st.accept = 1'b1;
          nxt_st.cmd    = (cmd_in == DDRPD_CMD_SRE) ? DDRPD_CMD_REF : cmd_in;
          nxt_st.strobe = 1'b1;
          if (cmd_in == DDRPD_CMD_REF) begin
            nxt_st.refi_cnt = '0; // RULE1
          end
          if (cmd_in == DDRPD_CMD_SRE) begin
            nxt_st.unlocked_entry = 1'b0;
            nxt_st.cke   = 1'b0;
            nxt_st.state = DDRPD_ST_SELF;
          end
        end else if (pd_req && !st_ff.strobe && gi.ready &&
                     !gi.busy_block && st_ff.cnt == '0) begin // RULE8
          nxt_st.state     = DDRPD_ST_ENTER;
          nxt_st.odt_async = slow_exit && !bank_open; // RULE13
          nxt_st.cnt       = `DDRPD_CNT_W'(`DDRPD_ANPD);
        end
      end
      DDRPD_ST_ENTER: begin
        if (st_ff.cnt == '0) begin // RULE13
          nxt_st.cke            = 1'b0; // RULE7
          nxt_st.cmd            = DDRPD_CMD_NOP;
          nxt_st.active         = bank_open; // RULE18
          nxt_st.unlocked_entry = !dll_locked; // RULE16 RULE17
          nxt_st.refi_n         = 4'h0;
          nxt_st.cnt = `DDRPD_CNT_W'(`DDRPD_PD_MIN + `DDRPD_CPDED); // RULE15
          nxt_st.state          = DDRPD_ST_DOWN;
        end
      end
      DDRPD_ST_DOWN: begin
        if (st_ff.cnt == '0 && (wake_req || st_ff.ref_due ||
            st_ff.refi_n >= 4'(`DDRPD_PD_MAX_REFI) - 4'h1)) begin // RULE19
          nxt_st.cke   = 1'b1; // RULE20
          nxt_st.cnt   = `DDRPD_CNT_W'(`DDRPD_ANPD + `DDRPD_XPDLL_CK);
          nxt_st.state = DDRPD_ST_EXIT;
        end
      end
      DDRPD_ST_EXIT: begin
        if (st_ff.cnt == '0) begin
          nxt_st.odt_async = 1'b0; // RULE13
          nxt_st.dll_reset = st_ff.unlocked_entry; // RULE17
          nxt_st.state     = DDRPD_ST_RUN;
          nxt_st.active    = 1'b0;
        end
      end
      DDRPD_ST_SELF: begin
        if (wake_req && !st_ff.strobe) begin
          nxt_st.cke   = 1'b1;
          nxt_st.cnt   = `DDRPD_CNT_W'(`DDRPD_XPDLL_CK);
          nxt_st.state = DDRPD_ST_EXIT;
        end
      end
      default: begin
        nxt_st.state = DDRPD_ST_RUN;
      end
    endcase
    if (st_ff.dll_reset && st_ff.state == DDRPD_ST_RUN) begin
      nxt_st.dll_reset = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff       <= '0;
      st_ff.state <= DDRPD_ST_RUN;
      st_ff.cke   <= 1'b1;
      st_ff.cmd   <= DDRPD_CMD_NOP;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    cmd_accept          = st_ff.accept;
    cke                 = st_ff.cke; // RULE14
    cmd_out             = st_ff.cmd;
    cmd_strobe          = st_ff.strobe;
    auto_refresh_rate   = st_ff.auto_rate;
    extended_range_flag = st_ff.ext_range;
    odt_async           = st_ff.odt_async;
    dll_reset_req       = st_ff.dll_reset;
    refresh_due         = st_ff.ref_due;
    in_power_down       = st_ff.state[2];
    active_pd           = st_ff.active;
  end
endmodule // ddrpd_host

// ### rtl/ddrpd_defines.svh
/*
  timing counts, field positions and temperature limits for the power-down host.
  assumes a 125 MHz controller clock and a DDR3 memory clock supplied outside.
*/
`ifndef DDRPD_DEFINES_SVH
`define DDRPD_DEFINES_SVH

`define DDRPD_CLK_PS          8000
`define DDRPD_MR2_AUTO_BIT    6
`define DDRPD_MR2_EXT_BIT     7
`define DDRPD_HOT_C           85
`define DDRPD_MAX_C           95
`define DDRPD_REFI_NORM_NS    7800
`define DDRPD_REFI_HOT_NS     3900
`define DDRPD_REFI_NORM_CYC   ((`DDRPD_REFI_NORM_NS * 1000) / `DDRPD_CLK_PS)
`define DDRPD_REFI_HOT_CYC    ((`DDRPD_REFI_HOT_NS * 1000) / `DDRPD_CLK_PS)
`define DDRPD_PD_MAX_REFI     9
`define DDRPD_ACT_PDEN        1
`define DDRPD_PRE_PDEN        1
`define DDRPD_REF_PDEN        1
`define DDRPD_RD_EXTRA        5
`define DDRPD_WR_EXTRA        4
`define DDRPD_WR_EXTRA_BC4    2
`define DDRPD_WRAP_EXTRA      1
`define DDRPD_TMOD            12
`define DDRPD_CPDED           1
`define DDRPD_PD_MIN          3
`define DDRPD_CKE_MIN         3
`define DDRPD_XPDLL_NS        24
`define DDRPD_XPDLL_CK        10
`define DDRPD_XPDLL_CYC       ((`DDRPD_XPDLL_NS * 1000 + `DDRPD_CLK_PS - 1) \
                               / `DDRPD_CLK_PS)
`define DDRPD_XP              3
`define DDRPD_ANPD            4
`define DDRPD_CNT_W           16

`endif

// ### rtl/ddrpd_pkg.sv
/*
  types shared by the power-down host modules.
  assumes ddrpd_defines.svh is compiled first.
*/
package ddrpd_pkg;
  `include "ddrpd_defines.svh"

  typedef enum logic [3:0] {
    DDRPD_CMD_NOP  = 4'h0,
    DDRPD_CMD_ACT  = 4'h1,
    DDRPD_CMD_PRE  = 4'h2,
    DDRPD_CMD_REF  = 4'h3,
    DDRPD_CMD_RD   = 4'h4,
    DDRPD_CMD_RDA  = 4'h5,
    DDRPD_CMD_WR   = 4'h6,
    DDRPD_CMD_WRA  = 4'h7,
    DDRPD_CMD_MRS  = 4'h8,
    DDRPD_CMD_MPR  = 4'h9,
    DDRPD_CMD_ZQ   = 4'hA,
    DDRPD_CMD_SRE  = 4'hB
  } ddrpd_cmd_type;

  typedef enum logic [4:0] {
    DDRPD_ST_RUN   = 5'h01,
    DDRPD_ST_ENTER = 5'h02,
    DDRPD_ST_DOWN  = 5'h04,
    DDRPD_ST_EXIT  = 5'h08,
    DDRPD_ST_SELF  = 5'h10
  } ddrpd_state_type;
endpackage

// ### rtl/ddrpd_gap_if.sv
/*
  carrier between the host top and its entry-spacing counter.
  assumes one clock domain.
*/
`timescale 1ns/1ps
interface ddrpd_gap_if;
  import ddrpd_pkg::*;
  logic                   issue;
  logic                   tick;
  ddrpd_cmd_type          cmd;
  logic [3:0]             rl;
  logic [3:0]             wl;
  logic [3:0]             wr;
  logic                   bc4_fixed;
  logic                   ready;
  logic                   busy_block;
  modport top (output issue, tick, cmd, rl, wl, wr, bc4_fixed,
               input ready, busy_block);
  modport gap (input issue, tick, cmd, rl, wl, wr, bc4_fixed,
               output ready, busy_block);
endinterface

// ### rtl/ddrpd_gap.sv
/*
  counts the least spacing between the last command and power-down entry.
  assumes commands are reported as one-cycle issue pulses.
*/
`timescale 1ns/1ps
module ddrpd_gap (
  input  wire logic  clock,
  input  wire logic  rst,
  ddrpd_gap_if.gap   g
);
  import ddrpd_pkg::*;

  typedef struct packed {
    logic [7:0] wait_cnt;
    logic       blk;
  } ddrpd_gap_type;

  ddrpd_gap_type st_ff;
  ddrpd_gap_type nxt_st;

  function automatic logic [7:0] gap_of(input ddrpd_cmd_type c,
      input logic [3:0] rl, input logic [3:0] wl, input logic [3:0] wr,
      input logic bc4);
    logic [7:0] w;
    w = 8'(wl) + 8'(wr) + (bc4 ? 8'(`DDRPD_WR_EXTRA_BC4)
                               : 8'(`DDRPD_WR_EXTRA));
    unique case (c)
      DDRPD_CMD_ACT: gap_of = 8'(`DDRPD_ACT_PDEN); // RULE10
      DDRPD_CMD_PRE: gap_of = 8'(`DDRPD_PRE_PDEN); // RULE10
      DDRPD_CMD_REF: gap_of = 8'(`DDRPD_REF_PDEN); // RULE10
      DDRPD_CMD_RD,
      DDRPD_CMD_RDA: gap_of = 8'(rl) + 8'(`DDRPD_RD_EXTRA); // RULE11
      DDRPD_CMD_WR:  gap_of = w; // RULE12
      DDRPD_CMD_WRA: gap_of = w + 8'(`DDRPD_WRAP_EXTRA); // RULE12
      DDRPD_CMD_MRS,
      DDRPD_CMD_MPR,
      DDRPD_CMD_ZQ:  gap_of = 8'(`DDRPD_TMOD); // RULE11
      default:       gap_of = 8'h00;
    endcase
  endfunction

  always_comb begin
    nxt_st = st_ff;
    if (g.issue) begin
      nxt_st.wait_cnt = gap_of(g.cmd, g.rl, g.wl, g.wr, g.bc4_fixed);
      nxt_st.blk      = (g.cmd != DDRPD_CMD_ACT) && (g.cmd != DDRPD_CMD_PRE)
                        && (g.cmd != DDRPD_CMD_REF); // RULE8 RULE9
    end else if (st_ff.wait_cnt != 8'h00) begin
      if (g.tick) begin
        nxt_st.wait_cnt = st_ff.wait_cnt - 8'h01;
      end
    end else begin
      nxt_st.blk = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign g.ready      = (st_ff.wait_cnt == 8'h00) && !g.issue;
  assign g.busy_block = st_ff.blk;
endmodule // ddrpd_gap

// ### verif/ddrpd_host_asserts.sv
/*
  concurrent checks on the power-down host ports.
  assumes bind onto ddrpd_host; mem_ck is synced here as in the host.
*/
`timescale 1ns/1ps
module ddrpd_host_asserts
  import ddrpd_pkg::*;
(
  input wire logic          clock,
  input wire logic          rst,
  input wire logic          mem_ck,
  input wire logic [3:0]    rl,
  input wire logic [3:0]    wl,
  input wire logic [3:0]    wr,
  input wire logic          bc4_fixed,
  input wire logic          slow_exit,
  input wire logic          dll_locked,
  input wire logic          bank_open,
  input wire logic [7:0]    temp_c,
  input wire logic          cmd_accept,
  input wire logic          cke,
  input wire ddrpd_cmd_type cmd_out,
  input wire logic          cmd_strobe,
  input wire logic          auto_refresh_rate,
  input wire logic          extended_range_flag,
  input wire logic          odt_async,
  input wire logic          dll_reset_req
);
  logic [2:0] sync_ff;
  logic [7:0] gap_ff;
  logic [7:0] need_ff;
  logic [7:0] nxt_need;
  logic [7:0] wbase;
  assign wbase = 8'(wl) + 8'(wr) + (bc4_fixed ? 8'h02 : 8'h04);
  always_comb begin
    case (cmd_out)
      DDRPD_CMD_RD, DDRPD_CMD_RDA: nxt_need = 8'(rl) + 8'h05;
      DDRPD_CMD_WR:  nxt_need = wbase;
      DDRPD_CMD_WRA: nxt_need = wbase + 8'h01;
      DDRPD_CMD_MRS: nxt_need = 8'h0C;
      default:       nxt_need = 8'h01;
    endcase
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_ff <= 3'h0;
      gap_ff  <= 8'h00;
      need_ff <= 8'h00;
    end else begin
      sync_ff <= {sync_ff[1:0], mem_ck};
      if (cmd_accept) begin
        gap_ff  <= 8'h00;
        need_ff <= nxt_need;
      end else if (sync_ff[1] && !sync_ff[2] && gap_ff != 8'hFF) begin
        gap_ff <= gap_ff + 8'h01;
      end
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_mr2_legal:
    assert property (!(auto_refresh_rate && extended_range_flag))
    else $error("both rate bits set");
  chk_sre_hot_refused:
    assert property (cmd_accept && !cke |->
      $past(temp_c) <= 8'h55 || $past(auto_refresh_rate) ||
      $past(extended_range_flag))
    else $error("self refresh taken while hot");
  chk_entry_gap:
    assert property ($fell(cke) |-> gap_ff >= need_ff)
    else $error("clock enable fell too soon");
  chk_entry_quiet:
    assert property ($fell(cke) && !cmd_accept |-> !cmd_strobe [*8])
    else $error("command during entry");
  chk_pd_min_hold:
    assert property ($fell(cke) |=> !cke [*8])
    else $error("power-down too short");
  chk_cke_high_hold:
    assert property ($rose(cke) |=> cke [*8])
    else $error("clock enable high too short");
  chk_odt_async_lead:
    assert property ($fell(cke) && slow_exit && !bank_open |-> odt_async)
    else $error("termination not asynchronous");
  chk_dll_reset_exit:
    assert property ($rose(cke) && !dll_locked |-> ##[0:300] dll_reset_req)
    else $error("no loop reset after exit");
endmodule // ddrpd_host_asserts

bind ddrpd_host ddrpd_host_asserts u_ddrpd_host_asserts (.clock, .rst,
  .mem_ck, .rl, .wl, .wr, .bc4_fixed, .slow_exit, .dll_locked, .bank_open,
  .temp_c, .cmd_accept, .cke, .cmd_out, .cmd_strobe, .auto_refresh_rate,
  .extended_range_flag, .odt_async, .dll_reset_req);

// ### verif/ddrpd_dev_model.sv
/*
  behavioural memory device on the host's command pins.
  assumes cke and commands are registered at each mem_ck rise.
*/
`timescale 1ns/1ps
module ddrpd_dev_model
  import ddrpd_pkg::*;
(
  input  wire logic          mem_ck,
  input  wire logic          rst,
  input  wire logic          cke,
  input  wire logic          cmd_strobe,
  input  wire ddrpd_cmd_type cmd_out,
  input  wire logic          auto_refresh_rate,
  input  wire logic          extended_range_flag,
  input  wire logic [7:0]    temp_c,
  output logic               dev_pd,
  output logic               dev_err
);
  logic cmd_hit;
  logic sr_ok;
  assign cmd_hit = cmd_strobe && cmd_out != DDRPD_CMD_NOP;
  assign sr_ok   = (auto_refresh_rate || extended_range_flag) ?
                   temp_c <= 8'h5F : temp_c <= 8'h55;
  always @(posedge mem_ck or posedge rst) begin
    if (rst) begin
      dev_pd  <= 1'b0;
      dev_err <= 1'b0;
    end else begin
      dev_pd <= !cke;
      if (cmd_hit && (dev_pd || (!cke && cmd_out != DDRPD_CMD_REF)))
        dev_err <= 1'b1;
      if (cmd_hit && !cke && !sr_ok) dev_err <= 1'b1;
      if (auto_refresh_rate && extended_range_flag) dev_err <= 1'b1;
    end
  end
endmodule // ddrpd_dev_model

// ### verif/ddrpd_host_bench.sv
/*
  self-checking bench for the power-down host with a device model.
  assumes mem_ck runs free at 64 ns, unrelated in phase to clock.
*/
`timescale 1ns/1ps
`include "ddrpd_defines.svh"
module ddrpd_host_bench;
  import ddrpd_pkg::*;
  logic          clock, rst, mem_ck, cmd_valid, bc4_fixed, pd_req, sr_req;
  logic          wake_req, want_auto_rate, want_ext_range, slow_exit;
  logic          dll_locked, bank_open, cmd_accept, cke, cmd_strobe;
  logic          auto_refresh_rate, extended_range_flag, odt_async;
  logic          dll_reset_req, refresh_due, in_power_down, active_pd;
  logic          dev_pd, dev_err, saw_dllr;
  logic [3:0]    rl, wl, wr;
  logic [7:0]    temp_c;
  ddrpd_cmd_type cmd_in, cmd_out;
  ddrpd_cmd_type exp_q[$];
  int            mismatches, cmp_count, i, n;
  int            seed = 86721;
  ddrpd_host u_ddrpd_host (.clock, .rst, .mem_ck, .cmd_valid, .cmd_in, .rl,
    .wl, .wr, .bc4_fixed, .pd_req, .sr_req, .wake_req, .want_auto_rate,
    .want_ext_range, .slow_exit, .dll_locked, .bank_open, .temp_c,
    .cmd_accept, .cke, .cmd_out, .cmd_strobe, .auto_refresh_rate,
    .extended_range_flag, .odt_async, .dll_reset_req, .refresh_due,
    .in_power_down, .active_pd);
  ddrpd_dev_model u_ddrpd_dev_model (.mem_ck, .rst, .cke, .cmd_strobe,
    .cmd_out, .auto_refresh_rate, .extended_range_flag, .temp_c, .dev_pd,
    .dev_err);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    mem_ck = 1'b0;
    #3;
    forever #32 mem_ck = ~mem_ck;
  end
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task send(ddrpd_cmd_type c);
    exp_q.push_back(c == DDRPD_CMD_SRE ? DDRPD_CMD_REF : c);
    cmd_in    <= c;
    cmd_valid <= 1'b1;
    n = 0;
    do @(posedge clock); while (cmd_accept !== 1'b1 && ++n < 300);
    cmd_valid <= 1'b0;
    check(cmd_accept, 1'b1);
  endtask
  task automatic wait_cke(logic v);
    int k;
    for (k = 0; k < 3000 && cke !== v; k++) @(posedge clock);
    check(cke, v);
  endtask
  // scoreboard of issued commands
  always @(posedge clock) begin
    if (dll_reset_req === 1'b1) saw_dllr = 1'b1;
    if (cmd_accept === 1'b1 && exp_q.size() > 0)
      check(8'(cmd_out), 8'(exp_q.pop_front()));
  end
  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    {cmd_valid, bc4_fixed, pd_req, sr_req, wake_req} = '0;
    {want_auto_rate, want_ext_range, slow_exit, bank_open} = '0;
    dll_locked = 1'b1;
    cmd_in = DDRPD_CMD_NOP;
    {rl, wl, wr} = {4'h5, 4'h5, 4'h6};
    temp_c = 8'h5A;
    rst = 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    send(DDRPD_CMD_REF);
    for (n = 0; n < 900 && refresh_due !== 1'b1; n++) @(posedge clock);
    check(n > `DDRPD_REFI_HOT_CYC - 8 && n < `DDRPD_REFI_HOT_CYC + 8, 1);
    for (i = 0; i < 4; i++) begin
      {want_auto_rate, want_ext_range} <= i[1:0];
      repeat (20) @(posedge clock);
      check({auto_refresh_rate, extended_range_flag},
            i == 3 ? 2'b10 : i[1:0]);
    end
    temp_c <= 8'h28;
    for (i = 1; i < 11; i++) begin
      {bank_open, slow_exit, dll_locked, bc4_fixed} <= 4'($random(seed));
      {rl, wl, wr} <= 12'h555 + 12'($random(seed) & 12'h333);
      @(posedge clock);
      send(ddrpd_cmd_type'(i));
      pd_req <= 1'b1;
      saw_dllr = 1'b0;
      wait_cke(1'b0);
      repeat (16) @(posedge clock);
      check({in_power_down, active_pd, dev_pd}, {1'b1, bank_open, 1'b1});
      pd_req   <= 1'b0;
      wake_req <= 1'b1;
      wait_cke(1'b1);
      wake_req <= 1'b0;
      repeat (300) @(posedge clock);
      check({in_power_down, saw_dllr}, {1'b0, !dll_locked});
    end
    {temp_c, want_auto_rate, want_ext_range} <= {8'h5A, 2'b00};
    repeat (20) @(posedge clock);
    cmd_in    <= DDRPD_CMD_SRE;
    cmd_valid <= 1'b1;
    n = 0;
    repeat (100) begin
      @(posedge clock);
      n += cmd_accept;
    end
    cmd_valid <= 1'b0;
    check(8'(n), 8'h00);
    {want_ext_range, dll_locked} <= 2'b11;
    repeat (20) @(posedge clock);
    send(DDRPD_CMD_SRE);
    repeat (40) @(posedge clock);
    check({in_power_down, cke, dev_pd}, 3'b001);
    wake_req <= 1'b1;
    wait_cke(1'b1);
    wake_req <= 1'b0;
    repeat (200) @(posedge clock);
    check({cke, dev_pd}, 2'b10);
    check(dev_err, 1'b0);
    check(8'(exp_q.size()), 8'h00);
    report_and_stop();
  end
endmodule // ddrpd_host_bench
